// file: include/lrc_pkg.sv
// Notes on behaviour
// [RL1] every procedure gets sixteen local registers; three hold linkage, thirteen free
// [RL2] four on-chip sets; a call normally takes a free set without spilling
// [RL3] when calls outnumber sets, the oldest set is written to its frame
// [RL4] the procedure stack grows upward and may sit anywhere in memory
// [RL5] contiguous frames, each opening with a save area for one set
// [RL6] a call keeps the caller's set and frame, builds callee's without software
// [RL7] branch-and-link only jumps and puts the return address in a global
// [RL8] system call is a local call whose target comes from a table entry
// [RL9] frames start on 64-byte boundaries; low six frame base bits read zero
// [RL10] a new frame's next free stack byte starts at its base plus 64
// [RL11] callee base is caller's next free stack byte rounded up to 64
// [RL12] call type goes into bits 0 to 2 of the first linkage register
// [RL13] a return to a spilled caller reloads its set from the frame first
`default_nettype none
package lrc_pkg;
  localparam int          LRC_NSETS      = 4;            // on-chip register sets
  localparam int          LRC_NREGS      = 16;           // registers per set
  localparam logic [2:0]  LRC_NSETS_C    = 3'h4;         // set count at counter width
  localparam int          LRC_ALIGN_BITS = 6;            // frame alignment, 64 bytes
  localparam logic [31:0] LRC_ALIGN_MASK = 32'h0000_003F;
  localparam logic [31:0] LRC_SAVE_SIZE  = 32'h0000_0040; // save area of one set, 64
  localparam logic [31:0] LRC_STACK_BASE = 32'h0000_1000; // first frame after reset
  // linkage register positions inside a set
  localparam logic [3:0]  LRC_R_PFL      = 4'h0;         // previous_frame_link + status
  localparam logic [3:0]  LRC_R_NFSB     = 4'h1;         // next_free_stack_byte
  localparam logic [3:0]  LRC_R_RIA      = 4'h2;         // return_instruction_address
  localparam logic [3:0]  LRC_R_LAST     = 4'hF;
  // return status codes
  localparam logic [2:0]  LRC_RS_LOCAL   = 3'h0;
  localparam logic [2:0]  LRC_RS_FAULT   = 3'h1;
  localparam logic [1:0]  LRC_RS_SUPV_HI = 2'h1;         // 01t, t = trace before call
  localparam logic [2:0]  LRC_RS_IDLE    = 3'h6;
  localparam logic [2:0]  LRC_RS_INTR    = 3'h7;
  // call kinds on the command port
  localparam logic [1:0]  LRC_K_LOCAL    = 2'h0;
  localparam logic [1:0]  LRC_K_SYSTEM   = 2'h1;
  localparam logic [1:0]  LRC_K_BAL      = 2'h2;
  localparam logic [1:0]  LRC_K_IMPLICIT = 2'h3;
  // procedure table entry: low two bits tag a privileged procedure
  localparam logic [1:0]  LRC_ENTRY_SUPV = 2'h2;

  typedef enum logic [2:0] {
    LRC_S_IDLE   = 3'b000,
    LRC_S_TBL    = 3'b001,
    LRC_S_SPILL  = 3'b011,
    LRC_S_LINK   = 3'b010,
    LRC_S_RELOAD = 3'b110,
    LRC_S_INIT   = 3'b100
  } lrc_state_t;

  // round up to the next frame boundary
  function automatic logic [31:0] lrc_align_up(input logic [31:0] a);
    return (a + LRC_ALIGN_MASK) & ~LRC_ALIGN_MASK;
  endfunction : lrc_align_up

  // byte address of a saved register; stored low base bits are ignored
  function automatic logic [31:0] lrc_word_addr(input logic [31:0] base,
                                                input logic [3:0]  idx);
    return {base[31:LRC_ALIGN_BITS], 6'h00} + {26'h0, idx, 2'h0};
  endfunction : lrc_word_addr
endpackage : lrc_pkg
`default_nettype wire

// file: rtl/lrc_set_store.sv
`timescale 1ns/1ns
`default_nettype none
// four sets of sixteen words, one write port, four combinational read ports
module lrc_set_store (
  input  wire logic             ref_clk,  // processor clock
  input  wire logic             we,       // write strobe
  input  wire logic [5:0]       waddr,    // {set, register}
  input  wire logic [31:0]      wdata,    // write data
  input  wire logic [3:0][5:0]  raddr,    // read addresses
  output logic      [3:0][31:0] rdata     // read data, same cycle
);
  import lrc_pkg::*;

  logic [31:0] mem [0:LRC_NSETS*LRC_NREGS-1];

  // no reset: contents are defined by linkage writes or reloads before use
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rdata[i] = mem[raddr[i]];
    end
  end
endmodule : lrc_set_store
`default_nettype wire

// file: rtl/lrc_cache.sv
`timescale 1ns/1ns
`default_nettype none
// local register set cache with procedure stack spill and reload
module lrc_cache (
  input  wire logic        ref_clk,         // processor clock, 125 MHz
  input  wire logic        rst_n,           // synchronous reset, active low
  input  wire logic        call_req,        // call command, one-cycle pulse
  input  wire logic [1:0]  call_kind,       // local, system, branch-link, implicit
  input  wire logic [31:0] call_target,     // target address (not for system calls)
  input  wire logic [31:0] call_ret_ip,     // address after the call instruction
  input  wire logic [7:0]  call_index,      // procedure table index
  input  wire logic [2:0]  impl_code,       // return status for implicit calls
  input  wire logic [31:0] proc_table_base, // procedure table base address
  input  wire logic        user_mode,       // caller runs in user mode
  input  wire logic        trace_en,        // trace enable before the call
  input  wire logic        ret_req,         // return command, one-cycle pulse
  input  wire logic [3:0]  lr_sel,          // local register of current set
  input  wire logic        lr_we,           // local register write
  input  wire logic [31:0] lr_wdata,        // local register write data
  input  wire logic [31:0] mem_rdata,       // memory read data
  input  wire logic        mem_ack,         // memory done, one-cycle pulse
  output logic             busy,            // commands refused while high
  output logic [31:0]      lr_rdata,        // local register read data
  output logic             resume_valid,    // control transfer pulse
  output logic [31:0]      resume_addr,     // where execution continues
  output logic [2:0]       ret_status,      // status of the last return
  output logic [31:0]      link_global,     // branch-and-link return address
  output logic [31:0]      current_frame_base, // frame base, low six bits zero
  output logic [2:0]       sets_cached,     // sets held on chip
  output logic             mem_req,         // memory request, held to ack
  output logic             mem_we,          // memory write
  output logic [31:0]      mem_addr,        // memory byte address
  output logic [31:0]      mem_wdata        // memory write data
);
  import lrc_pkg::*;

  typedef struct packed {
    lrc_state_t  st;
    logic [1:0]  cur;      // set of the running procedure
    logic [2:0]  cached;   // live sets on chip, 1..4
    logic [3:0]  cnt;      // word counter for spill, reload, linkage
    logic [2:0]  ctype;    // return status being recorded
    logic [31:0] ret_ip;
    logic [31:0] target;
    logic [31:0] nfsb;     // caller's next free stack byte
    logic [31:0] fb;
    logic [31:0] link_g;
    logic [31:0] res_addr;
    logic [31:0] lr_rdata;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [2:0]  ret_stat;
    logic        res_v;
    logic        mem_req;
    logic        mem_we;
    logic        busy;
  } lrc_regs_t;

  localparam lrc_regs_t LRC_RST = '{st: LRC_S_INIT, cached: 3'h1, fb: LRC_STACK_BASE,
                                    busy: 1'b1, default: '0};

  lrc_regs_t        r;
  lrc_regs_t        n;
  logic             st_we;
  logic [5:0]       st_waddr;
  logic [31:0]      st_wdata;
  logic [3:0][5:0]  ra;
  logic [3:0][31:0] rd;

  // every procedure owns a whole set of sixteen words
  lrc_set_store u_store (  // RL1
    .ref_clk (ref_clk),
    .we      (st_we),
    .waddr   (st_waddr),
    .wdata   (st_wdata),
    .raddr   (ra),
    .rdata   (rd)
  );

  // read port use: 0 spill data or caller r1, 1 frame link, 2 return ip, 3 software
  always_comb begin
    if (r.st == LRC_S_SPILL) begin
      ra[0] = {r.cur + 2'h1, r.cnt};        // oldest set sits just after the newest
      ra[1] = {r.cur + 2'h2, LRC_R_PFL};    // its successor links to its frame
    end else begin
      ra[0] = {r.cur, LRC_R_NFSB};
      ra[1] = {r.cur, LRC_R_PFL};
    end
    ra[2] = {r.cur, LRC_R_RIA};
    ra[3] = {r.cur, lr_sel};
  end

  // next-state logic for the whole block
  always_comb begin
    n        = r;
    n.res_v  = 1'b0;
    st_we    = 1'b0;
    st_waddr = {r.cur, LRC_R_PFL};
    st_wdata = '0;
    unique case (r.st)
      // first frame after reset: next free byte just past its save area
      LRC_S_INIT: begin
        st_we    = 1'b1;
        st_waddr = {r.cur, LRC_R_NFSB};
        st_wdata = r.fb + LRC_SAVE_SIZE;  // RL10
        n.st     = LRC_S_IDLE;
      end
      LRC_S_IDLE: begin
        n.lr_rdata = rd[3];
        // software access only while idle so the write port is never shared
        if (lr_we) begin
          st_we    = 1'b1;
          st_waddr = {r.cur, lr_sel};
          st_wdata = lr_wdata;
        end
        if (call_req) begin
          n.ret_ip = call_ret_ip;
          n.target = call_target;
          n.nfsb   = rd[0];
          n.cnt    = 4'h0;
          n.ctype  = (call_kind == LRC_K_IMPLICIT) ? impl_code : LRC_RS_LOCAL;
          unique case (call_kind)
            LRC_K_BAL: begin
              n.link_g   = call_ret_ip;  // RL7
              n.res_addr = call_target;  // RL7
              n.res_v    = 1'b1;
            end
            LRC_K_SYSTEM: begin
              n.st       = LRC_S_TBL;  // RL8
              n.mem_req  = 1'b1;
              n.mem_we   = 1'b0;
              n.mem_addr = proc_table_base + {22'h0, call_index, 2'h0};
            end
            default: begin
              // a free set is taken directly; only a full cache spills
              n.st = (r.cached == LRC_NSETS_C) ? LRC_S_SPILL : LRC_S_LINK;  // RL2
            end
          endcase
        end else if (ret_req) begin
          n.ret_stat = rd[1][2:0];
          n.fb       = {rd[1][31:LRC_ALIGN_BITS], 6'h00};  // RL9
          n.res_addr = rd[2];
          n.cnt      = 4'h0;
          if (r.cached == 3'h1) begin
            n.st = LRC_S_RELOAD;  // RL13
          end else begin
            n.cur    = r.cur - 2'h1;
            n.cached = r.cached - 3'h1;
            n.res_v  = 1'b1;
          end
        end
      end
      // fetch the table entry, then proceed like a local call; a privileged entry called from user mode records status 01t
      LRC_S_TBL: begin
        if (mem_ack) begin
          n.mem_req = 1'b0;
          n.target  = {mem_rdata[31:2], 2'h0};  // RL8
          if (mem_rdata[1:0] == LRC_ENTRY_SUPV && user_mode) begin
            n.ctype = {LRC_RS_SUPV_HI, trace_en};  // RL12
          end
          n.st = (r.cached == LRC_NSETS_C) ? LRC_S_SPILL : LRC_S_LINK;
        end
      end
      // write the oldest set word by word into the save area of its frame
      LRC_S_SPILL: begin
        if (!r.mem_req) begin
          n.mem_req   = 1'b1;  // RL3
          n.mem_we    = 1'b1;
          n.mem_addr  = lrc_word_addr(rd[1], r.cnt);  // RL5
          n.mem_wdata = rd[0];
        end else if (mem_ack) begin
          n.mem_req = 1'b0;
          n.cnt     = r.cnt + 4'h1;
          if (r.cnt == LRC_R_LAST) begin
            n.cached = r.cached - 3'h1;  // RL3
            n.cnt    = 4'h0;
            n.st     = LRC_S_LINK;
          end
        end
      end
      // build the callee's linkage; the caller's set is left untouched
      LRC_S_LINK: begin
        st_we    = 1'b1;  // RL6
        st_waddr = {r.cur + 2'h1, r.cnt};
        n.cnt    = r.cnt + 4'h1;
        unique case (r.cnt[1:0])
          2'h0:    st_wdata = {r.fb[31:LRC_ALIGN_BITS], 3'h0, r.ctype};  // RL12
          2'h1:    st_wdata = lrc_align_up(r.nfsb) + LRC_SAVE_SIZE;  // RL10
          default: st_wdata = r.ret_ip;
        endcase
        if (r.cnt == LRC_R_RIA) begin
          n.cur      = r.cur + 2'h1;
          n.cached   = r.cached + 3'h1;
          n.fb       = lrc_align_up(r.nfsb);  // RL11 RL4
          n.res_addr = r.target;
          n.res_v    = 1'b1;
          n.st       = LRC_S_IDLE;
        end
      end
      // caller's set was spilled: bring it back before resuming it
      LRC_S_RELOAD: begin
        if (!r.mem_req) begin
          n.mem_req  = 1'b1;
          n.mem_we   = 1'b0;
          n.mem_addr = lrc_word_addr(r.fb, r.cnt);  // RL13
        end else if (mem_ack) begin
          st_we     = 1'b1;
          st_waddr  = {r.cur - 2'h1, r.cnt};
          st_wdata  = mem_rdata;
          n.mem_req = 1'b0;
          n.cnt     = r.cnt + 4'h1;
          if (r.cnt == LRC_R_LAST) begin
            n.cur   = r.cur - 2'h1;
            n.res_v = 1'b1;
            n.st    = LRC_S_IDLE;
          end
        end
      end
      default: n.st = LRC_S_IDLE;
    endcase
    n.busy = (n.st != LRC_S_IDLE);
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r <= LRC_RST;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign busy               = r.busy;
  assign lr_rdata           = r.lr_rdata;
  assign resume_valid       = r.res_v;
  assign resume_addr        = r.res_addr;
  assign ret_status         = r.ret_stat;
  assign link_global        = r.link_g;
  assign current_frame_base = {r.fb[31:LRC_ALIGN_BITS], 6'h00};  // RL9
  assign sets_cached        = r.cached;
  assign mem_req            = r.mem_req;
  assign mem_we             = r.mem_we;
  assign mem_addr           = r.mem_addr;
  assign mem_wdata          = r.mem_wdata;
endmodule : lrc_cache
`default_nettype wire

// file: verification/lrc_cache_checker.sv
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the call/return engine
module lrc_cache_checker
  import lrc_pkg::*;
(
  input wire logic        ref_clk,            // clock
  input wire logic        rst_n,              // sync reset, low
  input wire logic        call_req,           // call pulse
  input wire logic [1:0]  call_kind,          // call kind
  input wire logic [31:0] call_target,        // call target
  input wire logic        ret_req,            // return pulse
  input wire logic        mem_ack,            // memory ack
  input wire logic        busy,               // busy
  input wire logic        resume_valid,       // resume pulse
  input wire logic [31:0] resume_addr,        // resume address
  input wire logic [31:0] current_frame_base, // frame base
  input wire logic [2:0]  sets_cached,        // sets on chip
  input wire logic        mem_req,            // memory request
  input wire logic        mem_we,             // memory write
  input wire logic [31:0] mem_addr            // memory address
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a command counts only when the engine is idle
  wire tk = call_req && !busy;
  wire rt = ret_req && !call_req && !busy;

  a_bal_jump: assert property (tk && call_kind == LRC_K_BAL |=> resume_valid
    && resume_addr == $past(call_target)) else $error("bal target wrong");
  a_frame_align: assert property (current_frame_base[5:0] == 6'h00)
    else $error("frame base not aligned");
  a_set_count: assert property (sets_cached inside {[3'h1:3'h4]})
    else $error("set count out of range");
  a_call_fast: assert property (tk && call_kind == LRC_K_LOCAL && sets_cached < 3'h4
    |=> !mem_req [*3] ##1 resume_valid) else $error("local call not served on chip");
  a_spill_start: assert property (tk && call_kind == LRC_K_LOCAL && sets_cached == 3'h4
    |-> ##[1:8] mem_req && mem_we) else $error("no spill on full cache");
  a_ret_fast: assert property (rt && sets_cached > 3'h1 |=> resume_valid)
    else $error("return not immediate");
  a_reload_read: assert property (rt && sets_cached == 3'h1
    |=> ##[0:8] mem_req && !mem_we) else $error("no reload read");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we)) else $error("memory request changed before ack");
  // only a branch-and-link, or a return while the caller's set is still on chip, is answered without the engine going busy
  a_busy_cmd: assert property (tk && call_kind != LRC_K_BAL |=> busy)
    else $error("call taken without going busy");
  // spill words leave in register order, one word apart in the save area
  a_spill_step: assert property (mem_req && mem_we && mem_ack && mem_addr[5:2] != 4'hF
    |=> ##1 mem_req && mem_we && mem_addr == $past(mem_addr, 2) + 32'h4)
    else $error("spill words not ascending");
endmodule : lrc_cache_checker

bind lrc_cache lrc_cache_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .call_req(call_req), .call_kind(call_kind), .call_target(call_target),
  .ret_req(ret_req), .mem_ack(mem_ack), .busy(busy), .resume_valid(resume_valid),
  .resume_addr(resume_addr), .current_frame_base(current_frame_base),
  .sets_cached(sets_cached), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr));
`default_nettype wire

// file: verification/lrc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// stack memory: answers each request after 0 to 3 idle cycles
module lrc_mem_model (
  input  wire logic        ref_clk,          // clock
  input  wire logic        mem_req,          // request, held to ack
  input  wire logic        mem_we,           // write
  input  wire logic [31:0] mem_addr,         // byte address
  input  wire logic [31:0] mem_wdata,        // write data
  output logic             mem_ack = 1'b0,   // one-cycle answer
  output logic [31:0]      mem_rdata = 32'h0 // valid with ack only
);
  logic [31:0] mem [logic [31:0]];
  int          wait_n = 0;
  // no answer in the ack cycle itself: the request only drops one edge later
  always @(posedge ref_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // released data never shows the old word
    if (mem_req && !mem_ack) begin
      if (wait_n > 0) wait_n <= wait_n - 1;
      else begin
        mem_ack <= 1'b1;
        wait_n <= $urandom_range(3, 0);
        if (mem_we) mem[mem_addr] = mem_wdata;
        else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
      end
    end
  end
endmodule : lrc_mem_model
`default_nettype wire

// file: verification/lrc_cache_bench.sv
`timescale 1ns/1ns
`default_nettype none
module lrc_cache_bench;
  import lrc_pkg::*;
  logic        ref_clk, rst_n, call_req, user_mode, trace_en, ret_req, lr_we, mem_ack;
  logic        busy, resume_valid, mem_req, mem_we;
  logic [1:0]  call_kind;
  logic [2:0]  impl_code, ret_status, sets_cached;
  logic [3:0]  lr_sel;
  logic [7:0]  call_index;
  logic [31:0] call_target, call_ret_ip, proc_table_base, lr_wdata, mem_rdata, lr_rdata;
  logic [31:0] resume_addr, link_global, current_frame_base, mem_addr, mem_wdata, tgt;
  logic [31:0] fb[9], sp[9], ra[9], tg[9];
  logic [2:0]  st[9];
  int          bad_count, checks_done, d;
  // call mix: local, system priv/user, implicit codes, system from supervisor
  int kd[8] = '{0, 1, 3, 1, 3, 1, 3, 0};
  int es[8] = '{0, 3, 1, 2, 6, 0, 7, 0};
  int us[8] = '{0, 1, 0, 1, 0, 0, 0, 0};
  int tr[8] = '{0, 1, 0, 0, 0, 1, 0, 0};
  int pv[8] = '{0, 1, 0, 1, 0, 1, 0, 0};

  lrc_cache i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .call_req(call_req),
    .call_kind(call_kind), .call_target(call_target), .call_ret_ip(call_ret_ip),
    .call_index(call_index), .impl_code(impl_code), .proc_table_base(proc_table_base),
    .user_mode(user_mode), .trace_en(trace_en), .ret_req(ret_req), .lr_sel(lr_sel),
    .lr_we(lr_we), .lr_wdata(lr_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .busy(busy), .lr_rdata(lr_rdata), .resume_valid(resume_valid),
    .resume_addr(resume_addr), .ret_status(ret_status), .link_global(link_global),
    .current_frame_base(current_frame_base), .sets_cached(sets_cached),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
  lrc_mem_model i_mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // register access only while idle; read data lags the select by one edge
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(negedge ref_clk); lr_we = 1'b1; lr_sel = a; lr_wdata = v;
    @(negedge ref_clk); lr_we = 1'b0;
  endtask : wreg

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    @(negedge ref_clk); lr_sel = a;
    @(negedge ref_clk); chk("local reg", lr_rdata, e);
  endtask : rchk

  // one command pulse, then a bounded wait for the resume pulse
  task automatic pulse_cmd(input logic c);
    int n;
    @(negedge ref_clk); call_req = c; ret_req = !c;
    @(negedge ref_clk); call_req = 1'b0; ret_req = 1'b0;
    for (n = 0; n < 400 && resume_valid !== 1'b1; n++) @(negedge ref_clk);
    chk("resume", {31'h0, resume_valid}, 32'h1);
    chk("busy", {31'h0, busy}, 32'h0);
  endtask : pulse_cmd

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // watchdog well beyond the longest expected run
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial begin
    {rst_n, call_req, user_mode, trace_en, ret_req, lr_we} = '0;
    {call_kind, impl_code, lr_sel, call_index} = '0;
    {call_target, call_ret_ip, lr_wdata} = '0;
    proc_table_base = 32'h0000_8000;
    void'($urandom(32'h3f6f3684));
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    d = 0;
    fb[0] = 32'h0000_1000;
    chk("base", current_frame_base, fb[0]);
    rchk(4'h1, 32'h0000_1040);
    // eight nested calls: from the fourth on, each spills the oldest set
    for (int i = 0; i < 8; i++) begin
      sp[d] = fb[d] + 32'h40 + 32'($urandom_range(63, 0));
      tg[d] = $urandom;
      wreg(4'h1, sp[d]);
      wreg(4'h5, tg[d]);
      fb[d+1] = (sp[d] + 32'h3F) & 32'hFFFF_FFC0;
      ra[d+1] = $urandom & 32'hFFFF_FFFC;
      st[d+1] = 3'(es[i]);
      tgt = $urandom & 32'hFFFF_FFFC;
      {call_kind, user_mode, trace_en, impl_code} = {2'(kd[i]), 1'(us[i]), 1'(tr[i]), st[d+1]};
      call_ret_ip = ra[d+1];
      call_index = 8'($urandom);
      call_target = (call_kind == LRC_K_SYSTEM) ? $urandom : tgt;
      i_mem.mem[proc_table_base + {22'h0, call_index, 2'h0}] = tgt | 32'(pv[i] * 2);
      pulse_cmd(1'b1);
      d++;
      chk("target", resume_addr, tgt);
      chk("frame", current_frame_base, fb[d]);
      chk("sets", 32'(sets_cached), 32'(d < 4 ? d + 1 : 4));
      rchk(4'h0, {fb[d-1][31:6], 3'h0, st[d]});
      rchk(4'h1, fb[d] + 32'h40);
      rchk(4'h2, ra[d]);
    end
    tgt = $urandom & 32'hFFFF_FFFC;
    {call_kind, call_target, call_ret_ip} = {LRC_K_BAL, tgt, $urandom};
    pulse_cmd(1'b1);
    chk("link", link_global, call_ret_ip);
    chk("bal frame", current_frame_base, fb[d]);
    // unwind: the lower frames come back from memory
    while (d > 0) begin
      pulse_cmd(1'b0);
      chk("return", resume_addr, ra[d]);
      chk("status", 32'(ret_status), 32'(st[d]));
      d--;
      chk("frame", current_frame_base, fb[d]);
      rchk(4'h5, tg[d]);
      rchk(4'h1, sp[d]);
    end
    end_sim();
  end
endmodule : lrc_cache_bench
`default_nettype wire
